// ### hw/lmad_pkg.sv
package lmad_pkg;

    // Local space layout
    localparam logic [24:0] LOC_RES_BASE  = 25'h1FC0000;
    localparam logic [25:0] LOC_EMB_BYTES = 26'h0400000;
    localparam logic [1:0]  AREA_CTL      = 2'h0;
    localparam logic [1:0]  AREA_PIO      = 2'h1;
    localparam logic [1:0]  AREA_RSV      = 2'h2;
    localparam logic [1:0]  AREA_EMC      = 2'h3;

    // Control area pages (4KB each), image port takes 8000H-BFFFH
    localparam logic [3:0] PG_2D0    = 4'h0;
    localparam logic [3:0] PG_2D1    = 4'h1;
    localparam logic [3:0] PG_3DREG  = 4'h2;
    localparam logic [3:0] PG_3DCMD  = 4'h3;
    localparam logic [3:0] PG_2DCMD  = 4'h4;
    localparam logic [1:0] PG_IMG_HI = 2'h2;

    // Peripheral area 256B pages
    localparam logic [7:0] PIO_PCI = 8'h01;
    localparam logic [7:0] PIO_VGA = 8'h03;

    // Legacy display decode
    localparam logic [11:0] IO_GRP_B    = 12'h03B;
    localparam logic [11:0] IO_GRP_C    = 12'h03C;
    localparam logic [11:0] IO_GRP_D    = 12'h03D;
    localparam logic [2:0]  LEG_MEM_TOP = 3'h5;
    localparam int          LEG_BANK_SH = 12;

    // Byte order from address bits 26:25
    localparam logic [1:0] BO_LE    = 2'h0;
    localparam logic [1:0] BO_RSV   = 2'h1;
    localparam logic [1:0] BO_BE_DW = 2'h2;
    localparam logic [1:0] BO_BE_W  = 2'h3;

    // FIFO backing sizes
    localparam int          F3D_UNIT_SH = 14;
    localparam logic [6:0]  F3D_MAX_U   = 7'h40;
    localparam int          F2D_BASE_SH = 10;
    localparam logic [20:0] SZ_1K       = 21'h000400;
    localparam logic [20:0] SZ_8K       = 21'h002000;
    localparam logic [20:0] SZ_16K      = 21'h004000;
    localparam logic [20:0] SZ_32K      = 21'h008000;
    localparam logic [20:0] WORD_STEP   = 21'h000004;
    localparam int          TEX_SH      = 12;

    typedef enum logic [1:0] {SP_LINEAR, SP_IO, SP_LEGMEM} lmad_space_e;

    typedef enum logic [3:0] {
        TG_NONE, TG_MEM, TG_2D0, TG_2D1, TG_3DREG, TG_FIFO3D,
        TG_FIFO2D, TG_FIFOIMG, TG_VGAIO, TG_PCICFG, TG_EMCFG
    } lmad_tgt_e;

    typedef enum logic [1:0] {RS_EXT, RS_3D, RS_ZERO} lmad_rsrc_e;

    typedef struct packed {
        logic        valid;
        logic        we;
        lmad_space_e space;
        logic [26:0] addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } lmad_req_s;

    typedef struct packed {
        logic        valid;
        logic        we;
        lmad_tgt_e   kind;
        logic [24:0] addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } lmad_tgt_s;

    typedef struct packed {
        logic [24:0] base;
        logic [13:0] stride;
        logic [1:0]  fmt;
    } lmad_surf_s;

endpackage

// ### hw/lmad_decoder.sv
`timescale 1ns/1ps
// Notes on behaviour
// - 128MB window of four 32MB aliases, all reaching one 32MB local space.
// - Address bit 26 picks little or big endian for linear accesses; I/O and legacy window accesses stay little.
// - Bits 26:25 10 swaps dword bytes, 11 word bytes, 00 little.
// - Lower 31.75MB goes to display memory, top 256KB to resources.
// - Only the first 4MB of display memory is backed.
// - Resources split into control, peripheral, reserved and memory config areas.
// - Legacy display ports and PCI config mirrored inside local memory.
// - Decode ports 3Bx, 3Cx, 3Dx and banked 128KB window at A0000H.
// - Two 4KB 2D register pages, shared registers at equal offsets.
// - 3D state registers in one 4KB page, byte granular from host.
// - Stream loads of 3D state write whole 16-bit halfwords.
// - Host gives aligned data; 3D registers readable and writable.
// - 4KB 3D command port stores every write at its write pointer.
// - 3D FIFO backing sized in 16KB steps to 1MB, 16KB aligned.
// - 4KB 2D command port; backing of 1, 8, 16 or 32KB.
// - 16KB image port; backing of 1, 8, 16 or 32KB.
// - Texture area bounded by base and end in 4KB units.
// - 2D surfaces addressed from base, stride and pixel format.
module lmad_decoder
    import lmad_pkg::*;
#(
    parameter logic [25:0] EMB_BYTES = LOC_EMB_BYTES
) (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        ce,
    input  wire lmad_req_s   hreq,
    input  wire logic [31:0] tgt_rdata,
    input  wire logic [12:0] vga_bank,
    input  wire logic [10:0] f3d_base,
    input  wire logic [6:0]  f3d_units,
    input  wire logic [14:0] f2d_base,
    input  wire logic [1:0]  f2d_size,
    input  wire logic [14:0] img_base,
    input  wire logic [1:0]  img_size,
    input  wire logic [2:0]  fifo_flush,
    input  wire logic        st_wr,
    input  wire logic [10:0] st_idx,
    input  wire logic [15:0] st_data,
    input  wire logic [12:0] tex_base,
    input  wire logic [12:0] tex_end,
    input  wire lmad_surf_s  surf,
    input  wire logic [11:0] pix_x,
    input  wire logic [11:0] pix_y,
    output lmad_tgt_s        tgt_q,
    output logic             resp_valid_q,
    output logic [31:0]      resp_rdata_q,
    output logic             tex_hit_q,
    output logic [24:0]      pix_addr_q
);

    if (EMB_BYTES == 26'h0 || EMB_BYTES > {1'b0, LOC_RES_BASE}) begin : g_chk
        $error("EMB_BYTES must be nonzero and below the resource region");
    end

    logic [31:0] st3d [1024];
    logic [19:0] f3d_ptr_q;
    logic [19:0] f2d_ptr_q;
    logic [19:0] img_ptr_q;
    logic        rd_pend_q;
    lmad_rsrc_e  rd_src_q;
    logic [1:0]  rd_bo_q;
    logic [31:0] rd_3d_q;

    lmad_tgt_e   kind;
    logic [24:0] laddr;
    logic [1:0]  bo;
    logic [3:0]  sbe;
    logic [31:0] swd;
    logic        acc;
    logic [20:0] f3d_sz;
    logic [24:0] pio_port;

    // Byte lane reordering for data
    function automatic logic [31:0] swap_d(input logic [31:0] d, input logic [1:0] m);
        case (m)
            BO_BE_DW: swap_d = {d[7:0], d[15:8], d[23:16], d[31:24]};
            BO_BE_W:  swap_d = {d[23:16], d[31:24], d[7:0], d[15:8]};
            default:  swap_d = d;
        endcase
    endfunction

    // Byte lane reordering for enables
    function automatic logic [3:0] swap_be(input logic [3:0] b, input logic [1:0] m);
        case (m)
            BO_BE_DW: swap_be = {b[0], b[1], b[2], b[3]};
            BO_BE_W:  swap_be = {b[2], b[3], b[0], b[1]};
            default:  swap_be = b;
        endcase
    endfunction

    // Backing size of a 2D FIFO from its size code
    function automatic logic [20:0] f2_bytes(input logic [1:0] c);
        case (c)
            2'h0:    f2_bytes = SZ_1K;
            2'h1:    f2_bytes = SZ_8K;
            2'h2:    f2_bytes = SZ_16K;
            default: f2_bytes = SZ_32K;
        endcase
    endfunction

    // Pointer advance by one word, wrapping at the backing size
    function automatic logic [19:0] ptr_next(input logic [19:0] p, input logic [20:0] sz);
        logic [20:0] n;
        n = {1'b0, p} + WORD_STEP;
        ptr_next = (n >= sz) ? 20'h0 : n[19:0];
    endfunction

    // Legacy port groups 3Bx, 3Cx, 3Dx
    function automatic logic vga_port(input logic [15:0] p);
        vga_port = (p[15:4] == IO_GRP_B) || (p[15:4] == IO_GRP_C) || (p[15:4] == IO_GRP_D);
    endfunction

    // 3D FIFO size in 16KB units, zero and overlarge clamped
    always_comb begin
        if (f3d_units == 7'h0) begin
            f3d_sz = 21'(1) << F3D_UNIT_SH;
        end else if (f3d_units > F3D_MAX_U) begin
            f3d_sz = 21'(F3D_MAX_U) << F3D_UNIT_SH;
        end else begin
            f3d_sz = 21'(f3d_units) << F3D_UNIT_SH;
        end
    end

    // Address decode of the incoming request
    always_comb begin
        kind     = TG_NONE;
        laddr    = hreq.addr[24:0];
        bo       = BO_LE;
        pio_port = 25'h300 | 25'(hreq.addr[7:0]);
        if (hreq.space == SP_LINEAR) begin
            bo = hreq.addr[26:25];
            if (bo == BO_RSV) begin
                bo = BO_LE;
            end
            if (laddr >= LOC_RES_BASE) begin
                if (laddr[17:16] == AREA_CTL) begin
                    if (laddr[15:14] == PG_IMG_HI) begin
                        kind = TG_FIFOIMG;
                    end else if (laddr[15:12] == PG_2D0) begin
                        kind = TG_2D0;
                    end else if (laddr[15:12] == PG_2D1) begin
                        kind = TG_2D1;
                    end else if (laddr[15:12] == PG_3DREG) begin
                        kind = TG_3DREG;
                    end else if (laddr[15:12] == PG_3DCMD) begin
                        kind = TG_FIFO3D;
                    end else if (laddr[15:12] == PG_2DCMD) begin
                        kind = TG_FIFO2D;
                    end
                end else if (laddr[17:16] == AREA_PIO) begin
                    if (laddr[15:8] == PIO_PCI) begin
                        kind  = TG_PCICFG;
                        laddr = 25'(laddr[7:0]);
                    end else if (laddr[15:8] == PIO_VGA && vga_port(pio_port[15:0])) begin
                        kind  = TG_VGAIO;
                        laddr = pio_port;
                    end
                end else if (laddr[17:16] == AREA_EMC) begin
                    kind  = TG_EMCFG;
                    laddr = 25'(laddr[15:0]);
                end
            end else if ({1'b0, laddr} < EMB_BYTES) begin
                kind = TG_MEM;
            end
        end else if (hreq.space == SP_IO) begin
            if (vga_port(hreq.addr[15:0])) begin
                kind  = TG_VGAIO;
                laddr = 25'(hreq.addr[15:0]);
            end
        end else if (hreq.addr[19:17] == LEG_MEM_TOP) begin
            kind  = TG_MEM;
            laddr = 25'({vga_bank, {LEG_BANK_SH{1'b0}}}) + 25'(hreq.addr[16:0]);
            if ({1'b0, laddr} >= EMB_BYTES) begin
                kind = TG_NONE;
            end
        end
        sbe = swap_be(hreq.be, bo);
        swd = swap_d(hreq.wdata, bo);
        acc = ce && hreq.valid;
    end

    // Forwarded request to memory, register pages except the 3D state page, and FIFO backing
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tgt_q <= '0;
        end else if (ce) begin
            tgt_q.valid <= 1'b0;
            tgt_q.we    <= hreq.we;
            tgt_q.kind  <= kind;
            tgt_q.be    <= sbe;
            tgt_q.wdata <= swd;
            tgt_q.addr  <= laddr;
            if (hreq.valid && kind != TG_NONE && kind != TG_3DREG) begin
                if (kind == TG_FIFO3D || kind == TG_FIFO2D || kind == TG_FIFOIMG) begin
                    tgt_q.valid <= hreq.we;
                end else begin
                    tgt_q.valid <= 1'b1;
                end
            end
            // Offset inside a port is ignored, the pointer picks the spot
            if (kind == TG_FIFO3D) begin
                tgt_q.addr <= 25'({f3d_base, {F3D_UNIT_SH{1'b0}}}) + 25'(f3d_ptr_q);
            end else if (kind == TG_FIFO2D) begin
                tgt_q.addr <= 25'({f2d_base, {F2D_BASE_SH{1'b0}}}) + 25'(f2d_ptr_q);
            end else if (kind == TG_FIFOIMG) begin
                tgt_q.addr <= 25'({img_base, {F2D_BASE_SH{1'b0}}}) + 25'(img_ptr_q);
            end
        end
    end

    // FIFO write pointers, advanced on writes only
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            f3d_ptr_q <= '0;
            f2d_ptr_q <= '0;
            img_ptr_q <= '0;
        end else if (ce) begin
            if (fifo_flush[0]) begin
                f3d_ptr_q <= '0;
            end else if (acc && hreq.we && kind == TG_FIFO3D) begin
                f3d_ptr_q <= ptr_next(f3d_ptr_q, f3d_sz);
            end
            if (fifo_flush[1]) begin
                f2d_ptr_q <= '0;
            end else if (acc && hreq.we && kind == TG_FIFO2D) begin
                f2d_ptr_q <= ptr_next(f2d_ptr_q, f2_bytes(f2d_size));
            end
            if (fifo_flush[2]) begin
                img_ptr_q <= '0;
            end else if (acc && hreq.we && kind == TG_FIFOIMG) begin
                img_ptr_q <= ptr_next(img_ptr_q, f2_bytes(img_size));
            end
        end
    end

    // 3D state page: host bytes first, stream halfword wins on overlap
    always_ff @(posedge clock) begin
        if (ce) begin
            if (acc && hreq.we && kind == TG_3DREG) begin
                for (int b = 0; b < 4; b++) begin
                    if (sbe[b]) begin
                        st3d[laddr[11:2]][8*b +: 8] <= swd[8*b +: 8];
                    end
                end
            end
            if (st_wr) begin
                st3d[st_idx[10:1]][16*st_idx[0] +: 16] <= st_data;
            end
        end
    end

    // Read tracking stage
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rd_pend_q <= 1'b0;
            rd_src_q  <= RS_ZERO;
            rd_bo_q   <= BO_LE;
            rd_3d_q   <= '0;
        end else if (ce) begin
            rd_pend_q <= hreq.valid && !hreq.we;
            rd_bo_q   <= bo;
            rd_3d_q   <= st3d[laddr[11:2]];
            if (kind == TG_3DREG) begin
                rd_src_q <= RS_3D;
            end else if (kind == TG_NONE || kind == TG_FIFO3D ||
                         kind == TG_FIFO2D || kind == TG_FIFOIMG) begin
                rd_src_q <= RS_ZERO;
            end else begin
                rd_src_q <= RS_EXT;
            end
        end
    end

    // Read answer, returned in the requester's byte order
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            resp_valid_q <= 1'b0;
            resp_rdata_q <= '0;
        end else if (ce) begin
            resp_valid_q <= rd_pend_q;
            if (!rd_pend_q) begin
                resp_rdata_q <= '0;
            end else if (rd_src_q == RS_EXT) begin
                resp_rdata_q <= swap_d(tgt_rdata, rd_bo_q);
            end else if (rd_src_q == RS_3D) begin
                resp_rdata_q <= swap_d(rd_3d_q, rd_bo_q);
            end else begin
                resp_rdata_q <= '0;
            end
        end
    end

    // Texture window check on display memory accesses
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tex_hit_q <= 1'b0;
        end else if (ce) begin
            tex_hit_q <= acc && kind == TG_MEM && laddr[24:TEX_SH] >= tex_base &&
                         laddr[24:TEX_SH] <= tex_end;
        end
    end

    // Surface pixel address generator
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pix_addr_q <= '0;
        end else if (ce) begin
            pix_addr_q <= surf.base + 25'(pix_y * surf.stride) +
                          25'(25'(pix_x) << surf.fmt);
        end
    end

endmodule // lmad_decoder

// ### testbench/lmad_decoder_props.sv
`timescale 1ns/1ps
module lmad_decoder_chk
    import lmad_pkg::*;
#(
    parameter logic [25:0] EMB_BYTES = LOC_EMB_BYTES
) (
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic        ce,
    input wire lmad_req_s   hreq,
    input wire lmad_tgt_s   tgt_q,
    input wire logic        resp_valid_q,
    input wire logic [31:0] resp_rdata_q,
    input wire lmad_surf_s  surf,
    input wire logic [11:0] pix_x,
    input wire logic [11:0] pix_y,
    input wire logic [24:0] pix_addr_q
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic lin;
    logic mem;
    logic fport;
    // Linear request taken at this edge, backed memory, FIFO ports
    assign lin   = ce && hreq.valid && hreq.space == SP_LINEAR;
    assign mem   = lin && hreq.addr[24:0] < 25'(EMB_BYTES);
    assign fport = hreq.addr[24:12] inside {13'h1FC3, 13'h1FC4} || hreq.addr[24:14] == 11'h7F2;

    property p_rd_lat; ce && hreq.valid && !hreq.we ##1 ce |=> resp_valid_q; endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
    property p_rd_src;
        resp_valid_q && $past(ce) && $past(ce, 2) |-> $past(hreq.valid, 2) && !$past(hreq.we, 2);
    endproperty
    a_rd_src: assert property (p_rd_src) else $error("answer without read");
    property p_idle0; !resp_valid_q |-> resp_rdata_q == 32'h0; endproperty
    a_idle0: assert property (p_idle0) else $error("idle read data not zero");
    property p_fifo_rd; lin && !hreq.we && fport |=> !tgt_q.valid; endproperty
    a_fifo_rd: assert property (p_fifo_rd) else $error("FIFO port read forwarded");
    property p_fifo_wr; lin && hreq.we && hreq.addr[24:12] == 13'h1FC3 |=>
        tgt_q.valid && tgt_q.kind == TG_FIFO3D; endproperty
    a_fifo_wr: assert property (p_fifo_wr) else $error("3D port write lost");
    property p_mem; mem |=> tgt_q.valid && tgt_q.kind == TG_MEM &&
        tgt_q.addr == $past(hreq.addr[24:0]); endproperty
    a_mem: assert property (p_mem) else $error("memory alias misrouted");
    property p_nomem; lin && hreq.addr[24:0] >= 25'(EMB_BYTES) &&
        hreq.addr[24:0] < LOC_RES_BASE |=> !tgt_q.valid; endproperty
    a_nomem: assert property (p_nomem) else $error("unbacked memory forwarded");
    property p_swap_dw; mem && hreq.we && hreq.addr[26:25] == BO_BE_DW |=>
        tgt_q.wdata[7:0] == $past(hreq.wdata[31:24]) && tgt_q.be[0] == $past(hreq.be[3]);
    endproperty
    a_swap_dw: assert property (p_swap_dw) else $error("dword swap wrong");
    property p_swap_w; mem && hreq.we && hreq.addr[26:25] == BO_BE_W |=>
        tgt_q.wdata[7:0] == $past(hreq.wdata[15:8]) && tgt_q.be[2] == $past(hreq.be[3]);
    endproperty
    a_swap_w: assert property (p_swap_w) else $error("word swap wrong");
    property p_le; mem && hreq.we && !hreq.addr[26] |=>
        tgt_q.wdata == $past(hreq.wdata) && tgt_q.be == $past(hreq.be); endproperty
    a_le: assert property (p_le) else $error("little order altered");
    property p_pix; ce |=> pix_addr_q == 25'($past(surf.base) + 25'($past(pix_y)) *
        25'($past(surf.stride)) + (25'($past(pix_x)) << $past(surf.fmt))); endproperty
    a_pix: assert property (p_pix) else $error("surface address wrong");
endmodule // lmad_decoder_chk

bind lmad_decoder lmad_decoder_chk #(.EMB_BYTES(EMB_BYTES)) u_chk (
    .clock(clock), .rst_n(rst_n), .ce(ce), .hreq(hreq), .tgt_q(tgt_q),
    .resp_valid_q(resp_valid_q), .resp_rdata_q(resp_rdata_q), .surf(surf),
    .pix_x(pix_x), .pix_y(pix_y), .pix_addr_q(pix_addr_q));

// ### testbench/lmad_tgt_model.sv
`timescale 1ns/1ps
module lmad_tgt_model
    import lmad_pkg::*;
(
    input  wire logic      clock,
    input  wire lmad_tgt_s tgt,
    output logic [31:0]    tgt_rdata
);
    logic [31:0] junk_q = 32'h0;
    // Lines change every cycle when no read is answered
    always @(posedge clock) junk_q <= junk_q + 32'h9E3779B9;
    // Memory and mirrored registers answer in the same cycle as the read
    assign tgt_rdata = (tgt.valid && !tgt.we) ? {tgt.addr[15:0], ~tgt.addr[15:0]} : junk_q;
endmodule // lmad_tgt_model

// ### testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import lmad_pkg::*;
    logic        clock = 1'b0, rst_n = 1'b0, ce = 1'b1, st_wr = 1'b0, mon_on = 1'b0;
    lmad_req_s   hreq = '0;
    lmad_surf_s  surf = '0;
    lmad_tgt_s   tgt_q, e_t = '0;
    logic [31:0] tgt_rdata, resp_rdata_q, e_rd = '0, p_rd = '0;
    logic [12:0] vga_bank, tex_base = 13'h0001, tex_end = 13'h0002;
    logic [10:0] f3d_base, st_idx = '0;
    logic [14:0] f2d_base, img_base;
    logic [6:0]  f3d_units = 7'h02;
    logic [1:0]  f2d_size = 2'h0, img_size = 2'h1;
    logic [2:0]  fifo_flush = '0;
    logic [15:0] st_data = '0;
    logic [11:0] pix_x = '0, pix_y = '0;
    logic [24:0] pix_addr_q, fb [3];
    logic        resp_valid_q, tex_hit_q, e_rv = 1'b0, p_rv = 1'b0, e_tex = 1'b0;
    int          n_errors = 0, comparisons = 0;
    int          fsz [3] = '{32'h8000, 32'h400, 32'h2000};
    logic [24:0] fwin [3] = '{25'h1FC3000, 25'h1FC4000, 25'h1FC8000};
    logic [24:0] fmsk [3] = '{25'hFFC, 25'hFFC, 25'h3FFC};
    lmad_tgt_e   fk [3] = '{TG_FIFO3D, TG_FIFO2D, TG_FIFOIMG};
    logic [24:0] mc [6] = '{25'h0FFC, 25'h1000, 25'h2FFC, 25'h3000, 25'h0400000, 25'h1FBFFFC};
    logic [24:0] r_off [8] = '{25'h1FC0010, 25'h1FC1010, 25'h1FD0104, 25'h1FD03C4,
                               25'h1FD03A0, 25'h1FE0010, 25'h1FF0010, 25'h1FC5000};
    lmad_tgt_e   r_k [8] = '{TG_2D0, TG_2D1, TG_PCICFG, TG_VGAIO, TG_NONE, TG_NONE,
                             TG_EMCFG, TG_NONE};
    logic [24:0] r_ta [8] = '{25'h1FC0010, 25'h1FC1010, 25'h04, 25'h3C4, 25'h0, 25'h0,
                              25'h10, 25'h0};

    lmad_decoder DUT (.clock(clock), .rst_n(rst_n), .ce(ce), .hreq(hreq),
        .tgt_rdata(tgt_rdata), .vga_bank(vga_bank), .f3d_base(f3d_base),
        .f3d_units(f3d_units), .f2d_base(f2d_base), .f2d_size(f2d_size),
        .img_base(img_base), .img_size(img_size), .fifo_flush(fifo_flush), .st_wr(st_wr),
        .st_idx(st_idx), .st_data(st_data), .tex_base(tex_base), .tex_end(tex_end),
        .surf(surf), .pix_x(pix_x), .pix_y(pix_y), .tgt_q(tgt_q),
        .resp_valid_q(resp_valid_q), .resp_rdata_q(resp_rdata_q), .tex_hit_q(tex_hit_q),
        .pix_addr_q(pix_addr_q));
    lmad_tgt_model u_tgt (.clock(clock), .tgt(tgt_q), .tgt_rdata(tgt_rdata));

    // Clock
    always #25 clock = ~clock;

    // Random surface and pixel stream
    always @(posedge clock) begin
        surf  <= lmad_surf_s'(41'({$urandom, $urandom}));
        pix_x <= 12'($urandom);
        pix_y <= 12'($urandom);
    end

    // Expected byte order of data and enables
    function automatic logic [31:0] swd(logic [1:0] o, logic [31:0] d);
        if (o == BO_BE_DW) return {d[7:0], d[15:8], d[23:16], d[31:24]};
        if (o == BO_BE_W) return {d[23:16], d[31:24], d[7:0], d[15:8]};
        return d;
    endfunction
    function automatic logic [3:0] swb(logic [1:0] o, logic [3:0] b);
        if (o == BO_BE_DW) return {b[0], b[1], b[2], b[3]};
        if (o == BO_BE_W) return {b[2], b[3], b[0], b[1]};
        return b;
    endfunction
    function automatic logic [31:0] mw(logic [24:0] a);
        return {a[15:0], ~a[15:0]};
    endfunction

    task automatic chk(string nm, logic [95:0] seen, logic [95:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic test_done;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // One request per cycle, expectation set for the following cycle
    task automatic step(lmad_space_e sp, logic we, logic [26:0] a, logic [3:0] be,
                        logic [31:0] d, lmad_tgt_e k, logic [24:0] ta, logic [31:0] rd);
        hreq <= '{1'b1, we, sp, a, be, d};
        @(posedge clock);
        e_t   = '{k != TG_NONE, we, k, ta, swb(a[26:25], be), swd(a[26:25], d)};
        e_rv  = !we;
        e_rd  = rd;
        e_tex = k == TG_MEM && ta[24:12] >= tex_base && ta[24:12] <= tex_end;
    endtask

    task automatic idle(int n);
        repeat (n) step(SP_LINEAR, 1'b1, 27'h1FE0000, 4'h0, 32'h0, TG_NONE, 25'h0, 32'h0);
    endtask

    // Output monitor, read answers pipelined by one cycle
    always @(negedge clock) begin
        if (mon_on) begin
            chk("tgt_valid", 96'(tgt_q.valid), 96'(e_t.valid));
            if (e_t.valid) chk("tgt_q", 96'(tgt_q), 96'(e_t));
            chk("resp_valid", 96'(resp_valid_q), 96'(p_rv));
            chk("resp_rdata", 96'(resp_rdata_q), 96'(p_rd));
            chk("tex_hit", 96'(tex_hit_q), 96'(e_tex));
        end
        p_rv = e_rv;
        p_rd = e_rd;
    end

    initial begin
        logic [1:0]  o;
        logic [24:0] a;
        logic        w;
        lmad_tgt_e   k;
        void'($urandom(32'hB176D8DC));
        vga_bank = 13'($urandom % 1000);
        f3d_base = 11'($urandom % 200);
        f2d_base = 15'($urandom % 3000);
        img_base = 15'($urandom % 3000);
        fb = '{{f3d_base, 14'h0}, {f2d_base, 10'h0}, {img_base, 10'h0}};
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        mon_on = 1'b1;
        // Memory through all four aliases, texture and 4MB edges first
        for (int i = 0; i < 48; i++) begin
            o = 2'($urandom);
            a = (i < 6) ? mc[i] : 25'($urandom) & 25'h03FFFFC;
            w = 1'($urandom);
            k = (a < 25'(LOC_EMB_BYTES)) ? TG_MEM : TG_NONE;
            step(SP_LINEAR, w, {o, a}, 4'($urandom), $urandom, k, a,
                 (w || k == TG_NONE) ? 32'h0 : swd(o, mw(a)));
        end
        // Resource region reads
        for (int i = 0; i < 8; i++)
            step(SP_LINEAR, 1'b0, {2'b00, r_off[i]}, 4'hF, 32'h0, r_k[i], r_ta[i],
                 (r_k[i] == TG_NONE) ? 32'h0 : mw(r_ta[i]));
        // Legacy ports and window
        step(SP_IO, 1'b0, 27'h3C5, 4'hF, 32'h0, TG_VGAIO, 25'h3C5, mw(25'h3C5));
        step(SP_IO, 1'b1, 27'h3A5, 4'hF, 32'h7, TG_NONE, 25'h0, 32'h0);
        step(SP_LEGMEM, 1'b0, 27'hA0010, 4'hF, 32'h0, TG_MEM, {vga_bank, 12'h010},
             mw({vga_bank, 12'h010}));
        step(SP_LEGMEM, 1'b0, 27'hC0000, 4'hF, 32'h0, TG_NONE, 25'h0, 32'h0);
        // Write-only ports: pointer wraps, offset ignored, reads give zero
        for (int p = 0; p < 3; p++) begin
            fifo_flush <= 3'h7;
            idle(1);
            fifo_flush <= 3'h0;
            for (int i = 0; i < fsz[p] / 4 + 3; i++) begin
                a = fwin[p] + (25'($urandom) & fmsk[p]);
                if (i == 2) step(SP_LINEAR, 1'b0, {2'b00, a}, 4'hF, 32'h0, TG_NONE, 25'h0, 32'h0);
                step(SP_LINEAR, 1'b1, {2'b00, a}, 4'($urandom), $urandom, fk[p],
                     fb[p] + 25'((i * 4) % fsz[p]), 32'h0);
            end
        end
        // 3D state page: byte writes, stream halfwords win
        step(SP_LINEAR, 1'b1, 27'h1FC2000, 4'hF, 32'h11223344, TG_NONE, 25'h0, 0);
        step(SP_LINEAR, 1'b1, 27'h1FC2000, 4'h2, 32'h0000AB00, TG_NONE, 25'h0, 0);
        step(SP_LINEAR, 1'b0, 27'h1FC2000, 4'hF, 32'h0, TG_NONE, 25'h0, 32'h1122AB44);
        st_data <= 16'hBEEF;
        st_wr <= 1'b1;
        step(SP_LINEAR, 1'b1, 27'h1FC2000, 4'h1, 32'h55, TG_NONE, 25'h0, 0);
        st_idx <= 11'h001;
        st_data <= 16'hCAFE;
        idle(1);
        st_wr <= 1'b0;
        step(SP_LINEAR, 1'b0, 27'h5FC2000, 4'hF, 32'h0, TG_NONE, 25'h0,
             swd(BO_BE_DW, 32'hCAFEBEEF));
        // Clock enable held low in mid-read: outputs frozen, then the answer resumes
        step(SP_LINEAR, 1'b0, 27'h100, 4'hF, 32'h0, TG_MEM, 25'h100, mw(25'h100));
        ce <= 1'b0;
        idle(1);
        mon_on = 1'b0;
        idle(3);
        ce <= 1'b1;
        @(negedge clock);
        chk("hold_tgt", 96'({tgt_q.valid, tgt_q.addr}), 96'({1'b1, 25'h100}));
        chk("hold_resp", 96'({resp_valid_q, resp_rdata_q}), 96'({1'b1, 32'hEFBEFECA}));
        @(negedge clock);
        chk("resume", 96'({resp_valid_q, resp_rdata_q}), 96'({1'b1, mw(25'h100)}));
        @(posedge clock);
        idle(3);
        mon_on = 1'b1;
        idle(3);
        test_done();
    end

    // Watchdog
    initial begin
        repeat (30000) @(posedge clock);
        n_errors++;
        test_done();
    end
endmodule // tb_top
